// >>> rtl/dor_regs.sv
// Purpose: dac output route, volume link, driver pop reduction and digital volume registers
// Assumes: register port and samples are on core_clk_i; srst_i synchronous active high
// Notes: outputs are registered, so register effects show one cycle after the write
`timescale 1ns/100ps
module dor_regs #(
   parameter int SAMPLE_W = 24,
   parameter int TICK_NS = dor_pkg::DOR_TICK_NS,
   parameter int RAMP_STEPS = dor_pkg::DOR_RAMP_STEPS
) (
   input wire logic core_clk_i,
   input wire logic srst_i,
   input wire logic reg_wr_i,
   input wire logic [6:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   output logic left_mixer_path_o,
   output logic left_lineout_path_o,
   output logic left_highpower_path_o,
   output logic right_mixer_path_o,
   output logic right_lineout_path_o,
   output logic right_highpower_path_o,
   output logic cm_bandgap_sel_o,
   output logic left_mute_o,
   output logic [6:0] left_atten_o,
   output logic right_mute_o,
   output logic [6:0] right_atten_o,
   input wire logic drv_power_req_i,
   output logic drv_on_o,
   output logic drv_ramp_step_o,
   output logic drv_ramp_done_o,
   input wire logic sample_valid_i,
   input wire logic signed [SAMPLE_W-1:0] left_sample_i,
   input wire logic signed [SAMPLE_W-1:0] right_sample_i,
   output logic sample_valid_o,
   output logic signed [SAMPLE_W-1:0] left_sample_o,
   output logic signed [SAMPLE_W-1:0] right_sample_o
);
   import dor_pkg::*;
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (srst_i);

   localparam int TICK_CYC = (TICK_NS + DOR_CLK_PERIOD_NS - 1) / DOR_CLK_PERIOD_NS;
   localparam int TDIV_W = $clog2(TICK_CYC + 1);
   localparam int STEP_W = $clog2(RAMP_STEPS + 1);

   logic [7:0] sw_q;
   logic [7:0] pop_q;
   logic [7:0] lvol_q;
   logic [7:0] rvol_q;
   logic [TDIV_W-1:0] tdiv_q;
   logic tick_q;
   dor_drv_state_t st_q;
   logic req_q;
   logic [DOR_CNT_W-1:0] cnt_q;
   logic [STEP_W-1:0] steps_q;
   logic [1:0] lroute;
   logic [1:0] rroute;
   logic [1:0] link;
   logic [2:0] dly_code;
   logic [1:0] ramp_code;
   logic [DOR_CNT_W-1:0] dly_us;
   logic [DOR_CNT_W-1:0] ramp_us;

   assign lroute = sw_q[DOR_LROUTE_HI:DOR_LROUTE_LO];
   assign rroute = sw_q[DOR_RROUTE_HI:DOR_RROUTE_LO];
   assign link = sw_q[DOR_LINK_HI:DOR_LINK_LO];
   assign dly_code = pop_q[DOR_DLY_HI:DOR_DLY_LO];
   assign ramp_code = pop_q[DOR_RAMP_HI:DOR_RAMP_LO];
   // reserved delay codes fall back to no delay
   assign dly_us = (dly_code <= 3'h5) ? DOR_DLY_US[dly_code] : '0;
   assign ramp_us = DOR_RAMP_US[ramp_code];

   // register writes; all bits stored as written
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         sw_q <= DOR_RST_SWITCH;
         pop_q <= DOR_RST_POP;
         lvol_q <= DOR_RST_VOL;
         rvol_q <= DOR_RST_VOL;
      end else if (reg_wr_i) begin
         if (reg_addr_i == DOR_OFS_SWITCH) sw_q <= reg_wdata_i;
         if (reg_addr_i == DOR_OFS_POP) pop_q <= reg_wdata_i;
         if (reg_addr_i == DOR_OFS_LVOL) lvol_q <= reg_wdata_i;
         if (reg_addr_i == DOR_OFS_RVOL) rvol_q <= reg_wdata_i;
      end
   end

   // read data, one cycle after the address; other offsets read zero
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         reg_rdata_o <= '0;
      end else begin
         unique case (reg_addr_i)
            DOR_OFS_SWITCH: reg_rdata_o <= sw_q;
            DOR_OFS_POP: reg_rdata_o <= pop_q;
            DOR_OFS_LVOL: reg_rdata_o <= lvol_q;
            DOR_OFS_RVOL: reg_rdata_o <= rvol_q;
            default: reg_rdata_o <= '0;
         endcase
      end
   end

   // route decode; code 11 enables no path
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         left_mixer_path_o <= 1'b1;
         left_lineout_path_o <= 1'b0;
         left_highpower_path_o <= 1'b0;
         right_mixer_path_o <= 1'b1;
         right_lineout_path_o <= 1'b0;
         right_highpower_path_o <= 1'b0;
      end else begin
         left_mixer_path_o <= (lroute == DOR_ROUTE_MIX);
         left_lineout_path_o <= (lroute == DOR_ROUTE_LINE);
         left_highpower_path_o <= (lroute == DOR_ROUTE_HP);
         right_mixer_path_o <= (rroute == DOR_ROUTE_MIX);
         right_lineout_path_o <= (rroute == DOR_ROUTE_LINE);
         right_highpower_path_o <= (rroute == DOR_ROUTE_HP);
      end
   end

   // effective volume after linking; the whole register follows
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         left_mute_o <= DOR_RST_VOL[DOR_MUTE_BIT];
         left_atten_o <= DOR_RST_VOL[DOR_VOL_HI:0];
         right_mute_o <= DOR_RST_VOL[DOR_MUTE_BIT];
         right_atten_o <= DOR_RST_VOL[DOR_VOL_HI:0];
         cm_bandgap_sel_o <= 1'b0;
      end else begin
         {left_mute_o, left_atten_o} <= (link == DOR_LINK_L_FOLLOWS_R) ? rvol_q : lvol_q;
         {right_mute_o, right_atten_o} <= (link == DOR_LINK_R_FOLLOWS_L) ? lvol_q : rvol_q;
         cm_bandgap_sel_o <= pop_q[DOR_CM_BIT];
      end
   end

   // reference tick, one pulse per TICK_NS
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         tdiv_q <= '0;
         tick_q <= 1'b0;
      end else begin
         tick_q <= (tdiv_q == TDIV_W'(TICK_CYC - 1));
         tdiv_q <= (tdiv_q == TDIV_W'(TICK_CYC - 1)) ? '0 : tdiv_q + 1'b1;
      end
   end

   // driver power-on delay then ramp steps
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         st_q <= DOR_S_IDLE;
         req_q <= 1'b0;
         cnt_q <= '0;
         steps_q <= '0;
         drv_on_o <= 1'b0;
         drv_ramp_step_o <= 1'b0;
         drv_ramp_done_o <= 1'b0;
      end else begin
         req_q <= drv_power_req_i;
         drv_ramp_step_o <= 1'b0;
         if (!drv_power_req_i) begin
            st_q <= DOR_S_IDLE;
            drv_on_o <= 1'b0;
            drv_ramp_done_o <= 1'b0;
         end else begin
            unique case (st_q)
               DOR_S_IDLE: begin
                  if (!req_q) begin
                     cnt_q <= dly_us;
                     st_q <= DOR_S_DELAY;
                  end
               end
               DOR_S_DELAY: begin
                  if (cnt_q == '0) begin
                     st_q <= DOR_S_RAMP;
                     drv_on_o <= 1'b1;
                     cnt_q <= ramp_us;
                     steps_q <= STEP_W'(RAMP_STEPS);
                  end else if (tick_q) begin
                     cnt_q <= cnt_q - 1'b1;
                  end
               end
               DOR_S_RAMP: begin
                  if (steps_q == '0) begin
                     st_q <= DOR_S_ON;
                     drv_ramp_done_o <= 1'b1;
                  end else if (cnt_q == '0) begin
                     drv_ramp_step_o <= 1'b1;
                     steps_q <= steps_q - 1'b1;
                     cnt_q <= ramp_us;
                  end else if (tick_q) begin
                     cnt_q <= cnt_q - 1'b1;
                  end
               end
               DOR_S_ON: begin
                  st_q <= DOR_S_ON;
               end
            endcase
         end
      end
   end

   // 0.5 dB per code: mantissa per step, shift per twelve steps
   function automatic logic signed [SAMPLE_W-1:0] atten(input logic signed [SAMPLE_W-1:0] s,
         input logic [6:0] code);
      logic signed [SAMPLE_W+16:0] p;
      logic [6:0] frac;
      logic [6:0] shft;
      frac = 7'(code % 7'(DOR_STEPS_PER_HALF));
      shft = 7'(code / 7'(DOR_STEPS_PER_HALF));
      p = s * $signed({1'b0, DOR_GAIN_Q15[frac[3:0]]});
      p = p >>> DOR_GAIN_FRAC;
      p = p >>> shft;
      return p[SAMPLE_W-1:0];
   endfunction

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         sample_valid_o <= 1'b0;
         left_sample_o <= '0;
         right_sample_o <= '0;
      end else begin
         sample_valid_o <= sample_valid_i;
         if (sample_valid_i) begin
            left_sample_o <= left_mute_o ? '0 : atten(left_sample_i, left_atten_o);
            right_sample_o <= right_mute_o ? '0 : atten(right_sample_i, right_atten_o);
         end
      end
   end

   a_route_left_line: assert property (!$past(srst_i) && $past(lroute) == DOR_ROUTE_LINE |->
      left_lineout_path_o && !left_mixer_path_o && !left_highpower_path_o)
      else $error("left line route not selected");
   a_route_right_hp: assert property (!$past(srst_i) && $past(rroute) == DOR_ROUTE_HP |->
      right_highpower_path_o && !right_mixer_path_o && !right_lineout_path_o)
      else $error("right high-power route not selected");
   a_vol_link_left: assert property (!$past(srst_i) && $past(link) == DOR_LINK_L_FOLLOWS_R |->
      {left_mute_o, left_atten_o} == $past(rvol_q))
      else $error("left volume not following right");
   a_vol_indep_right: assert property (!$past(srst_i) && $past(link) != DOR_LINK_R_FOLLOWS_L |->
      {right_mute_o, right_atten_o} == $past(rvol_q))
      else $error("right volume not independent");
   sequence s_start_nodelay;
      st_q == DOR_S_IDLE && !req_q && drv_power_req_i && dly_code == 3'h0;
   endsequence
   a_delay_zero: assert property (s_start_nodelay ##1 drv_power_req_i |=> drv_on_o)
      else $error("zero delay did not power on in two cycles");
   a_delay_hold: assert property (st_q == DOR_S_DELAY && cnt_q != '0 && drv_power_req_i |=>
      !drv_on_o)
      else $error("driver on before delay expired");
   a_ramp_space: assert property (drv_ramp_step_o && ramp_code != 2'h0 && $stable(pop_q) |=>
      !drv_ramp_step_o)
      else $error("ramp steps too close");
   a_cm_select: assert property (!$past(srst_i) |-> cm_bandgap_sel_o == $past(pop_q[DOR_CM_BIT]))
      else $error("weak bias select mismatch");
   a_mute_reset: assert property ($past(srst_i) |-> lvol_q == DOR_RST_VOL && rvol_q == DOR_RST_VOL)
      else $error("volume registers not at reset value");
   a_mute_zero: assert property (sample_valid_i && left_mute_o |=> left_sample_o == '0)
      else $error("muted left channel not silent");
   a_unity_gain: assert property (sample_valid_i && !right_mute_o && right_atten_o == 7'h0 |=>
      right_sample_o == $past(right_sample_i))
      else $error("right 0 dB setting changed sample");
   a_route_left_hp: assert property (!$past(srst_i) && $past(lroute) == DOR_ROUTE_HP |->
      left_highpower_path_o && !left_mixer_path_o && !left_lineout_path_o)
      else $error("left high-power route not selected");
   a_route_left_mix: assert property (!$past(srst_i) && $past(lroute) == DOR_ROUTE_MIX |->
      left_mixer_path_o && !left_lineout_path_o && !left_highpower_path_o)
      else $error("left mixer route not selected");
   a_route_right_line: assert property (!$past(srst_i) && $past(rroute) == DOR_ROUTE_LINE |->
      right_lineout_path_o && !right_mixer_path_o && !right_highpower_path_o)
      else $error("right line route not selected");
   a_vol_link_right: assert property (!$past(srst_i) && $past(link) == DOR_LINK_R_FOLLOWS_L |->
      {right_mute_o, right_atten_o} == $past(lvol_q))
      else $error("right volume not following left");
   a_mute_right: assert property (sample_valid_i && right_mute_o |=>
      right_sample_o == '0)
      else $error("muted right channel not silent");
   a_ramp_done_hold: assert property (drv_ramp_done_o && drv_power_req_i |=>
      drv_ramp_done_o)
      else $error("ramp done dropped while request held");
endmodule

// >>> shared/dor_pkg.sv
// Purpose: constants for the dac output route and volume register bank
// Assumes: 8-bit control registers, one clock at 200 MHz
// Notes: delay and ramp times are kept in microseconds of the reference tick
package dor_pkg;
   // register offsets
   localparam logic [6:0] DOR_OFS_SWITCH = 7'h29;
   localparam logic [6:0] DOR_OFS_POP = 7'h2a;
   localparam logic [6:0] DOR_OFS_LVOL = 7'h2b;
   localparam logic [6:0] DOR_OFS_RVOL = 7'h2c;
   // reset values
   localparam logic [7:0] DOR_RST_SWITCH = 8'h00;
   localparam logic [7:0] DOR_RST_POP = 8'h00;
   localparam logic [7:0] DOR_RST_VOL = 8'h80;
   // field positions
   localparam int DOR_LROUTE_HI = 7;
   localparam int DOR_LROUTE_LO = 6;
   localparam int DOR_RROUTE_HI = 5;
   localparam int DOR_RROUTE_LO = 4;
   localparam int DOR_LINK_HI = 1;
   localparam int DOR_LINK_LO = 0;
   localparam int DOR_DLY_HI = 7;
   localparam int DOR_DLY_LO = 5;
   localparam int DOR_RAMP_HI = 3;
   localparam int DOR_RAMP_LO = 2;
   localparam int DOR_CM_BIT = 1;
   localparam int DOR_MUTE_BIT = 7;
   localparam int DOR_VOL_HI = 6;
   // route codes
   localparam logic [1:0] DOR_ROUTE_MIX = 2'h0;
   localparam logic [1:0] DOR_ROUTE_LINE = 2'h1;
   localparam logic [1:0] DOR_ROUTE_HP = 2'h2;
   // volume link codes
   localparam logic [1:0] DOR_LINK_L_FOLLOWS_R = 2'h1;
   localparam logic [1:0] DOR_LINK_R_FOLLOWS_L = 2'h2;
   // timing
   localparam int DOR_CLK_PERIOD_NS = 5;
   localparam int DOR_TICK_NS = 1000;
   localparam int DOR_CNT_W = 21;
   // power-on delays in microseconds, codes 0 to 5
   localparam logic [DOR_CNT_W-1:0] DOR_DLY_US [0:5] = '{21'h0, 21'h64, 21'h2710, 21'h186a0, 21'h61a80, 21'h1e8480};
   // ramp step intervals in microseconds: 0, 1, 2, 4 ms
   localparam logic [DOR_CNT_W-1:0] DOR_RAMP_US [0:3] = '{21'h0, 21'h3e8, 21'h7d0, 21'hfa0};
   localparam int DOR_RAMP_STEPS = 8;
   // 0.5 dB gain mantissas in q15; twelve steps make one halving
   localparam int DOR_STEPS_PER_HALF = 12;
   localparam int DOR_GAIN_FRAC = 15;
   localparam logic [15:0] DOR_GAIN_Q15 [0:11] = '{16'h8000, 16'h78d7, 16'h7215, 16'h6bb3, 16'h65ad, 16'h5ffd,
      16'h5a9e, 16'h558c, 16'h50c3, 16'h4c3f, 16'h47fb, 16'h43f4};
   typedef enum logic [1:0] {
      DOR_S_IDLE = 2'b00,
      DOR_S_DELAY = 2'b01,
      DOR_S_RAMP = 2'b10,
      DOR_S_ON = 2'b11
   } dor_drv_state_t;
endpackage

// >>> verification/dac_output_route_volume_regs_tb.sv
// Purpose: self-checking bench for the dac output route, link, pop reduction and digital volume registers
// Assumes: inputs driven on the falling edge; TICK_NS shortened to 10 so one reference tick is 2 cycles
// Notes: random stimulus from a fixed seed, with hand-picked corner values mixed in
`timescale 1ns/100ps
module dac_output_route_volume_regs_tb;
   import dor_pkg::*;
   localparam int TCK = 10;
   localparam int CPT = TCK / DOR_CLK_PERIOD_NS;
   logic core_clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic reg_wr_i = 1'b0;
   logic [6:0] reg_addr_i = 7'h00;
   logic [7:0] reg_wdata_i = 8'h00;
   logic drv_power_req_i = 1'b0;
   logic sample_valid_i = 1'b0;
   logic signed [23:0] left_sample_i = 24'h000000;
   logic signed [23:0] right_sample_i = 24'h000000;
   logic [7:0] reg_rdata_o;
   logic [2:0] lp;
   logic [2:0] rp;
   logic cm_bandgap_sel_o, left_mute_o, right_mute_o, drv_on_o, drv_ramp_step_o, drv_ramp_done_o, sample_valid_o;
   logic [6:0] left_atten_o;
   logic [6:0] right_atten_o;
   logic signed [23:0] left_sample_o;
   logic signed [23:0] right_sample_o;
   int errors = 0;
   int checks_done = 0;
   int cycles = 0;

   dor_regs #(.SAMPLE_W(24), .TICK_NS(TCK), .RAMP_STEPS(2)) dut_u (
      .core_clk_i(core_clk_i), .srst_i(srst_i), .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
      .left_mixer_path_o(lp[0]), .left_lineout_path_o(lp[1]), .left_highpower_path_o(lp[2]),
      .right_mixer_path_o(rp[0]), .right_lineout_path_o(rp[1]), .right_highpower_path_o(rp[2]),
      .cm_bandgap_sel_o(cm_bandgap_sel_o), .left_mute_o(left_mute_o), .left_atten_o(left_atten_o),
      .right_mute_o(right_mute_o), .right_atten_o(right_atten_o), .drv_power_req_i(drv_power_req_i),
      .drv_on_o(drv_on_o), .drv_ramp_step_o(drv_ramp_step_o), .drv_ramp_done_o(drv_ramp_done_o),
      .sample_valid_i(sample_valid_i), .left_sample_i(left_sample_i), .right_sample_i(right_sample_i),
      .sample_valid_o(sample_valid_o), .left_sample_o(left_sample_o), .right_sample_o(right_sample_o));

   initial begin
      forever #2.5 core_clk_i = ~core_clk_i;
   end

   task automatic stop_test;
      if (errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   always @(posedge core_clk_i) begin
      cycles++;
      if (cycles == 60000) begin
         errors++;
         stop_test();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // write, then wait until decoded outputs have settled
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(negedge core_clk_i);
      reg_wr_i = 1'b1;
      reg_addr_i = a;
      reg_wdata_i = d;
      @(negedge core_clk_i);
      reg_wr_i = 1'b0;
      @(negedge core_clk_i);
   endtask

   task automatic rd(input logic [6:0] a, output logic [7:0] d);
      @(negedge core_clk_i);
      reg_addr_i = a;
      @(negedge core_clk_i);
      d = reg_rdata_o;
   endtask

   task automatic send(input logic signed [23:0] l, input logic signed [23:0] r);
      @(negedge core_clk_i);
      sample_valid_i = 1'b1;
      left_sample_i = l;
      right_sample_i = r;
      @(negedge core_clk_i);
      sample_valid_i = 1'b0;
      chk(sample_valid_o, 1);
   endtask

   function automatic logic [2:0] path_of(input logic [1:0] c);
      return (c == 2'h0) ? 3'b001 : (c == 2'h1) ? 3'b010 : (c == 2'h2) ? 3'b100 : 3'b000;
   endfunction

   initial begin
      logic [7:0] d, lv, rv;
      logic [1:0] lk;
      logic signed [23:0] s;
      int t0, n, last, gap;
      void'($urandom(32'hbe7c39eb));
      repeat (12) @(negedge core_clk_i);
      srst_i = 1'b0;
      rd(DOR_OFS_SWITCH, d); chk(d, 8'h00);
      rd(DOR_OFS_POP, d); chk(d, 8'h00);
      rd(DOR_OFS_LVOL, d); chk(d, 8'h80);
      rd(DOR_OFS_RVOL, d); chk(d, 8'h80);
      chk({lp, rp, left_mute_o, right_mute_o, left_atten_o, right_atten_o}, {8'h27, 14'h0});
      wr(7'h28, 8'hff);
      rd(7'h28, d); chk(d, 8'h00);
      rd(DOR_OFS_LVOL, d); chk(d, 8'h80);
      for (int i = 0; i < 9; i++) begin
         lk = 2'($urandom);
         d = {2'(i / 3), 2'(i % 3), 2'b00, lk};
         wr(DOR_OFS_SWITCH, d);
         rd(DOR_OFS_SWITCH, lv); chk(lv, d);
         chk(lp, path_of(2'(i / 3)));
         chk(rp, path_of(2'(i % 3)));
      end
      for (int k = 0; k < 4; k++) begin
         lv = {1'b0, (k == 0) ? 7'h7f : 7'($urandom)};
         rv = {1'($urandom), 7'($urandom)};
         wr(DOR_OFS_LVOL, lv);
         wr(DOR_OFS_RVOL, rv);
         wr(DOR_OFS_SWITCH, {6'h00, 2'(k)});
         chk({left_mute_o, left_atten_o}, (k == 1) ? rv : lv);
         chk({right_mute_o, right_atten_o}, (k == 2) ? lv : rv);
      end
      wr(DOR_OFS_POP, 8'h02);
      chk(cm_bandgap_sel_o, 1);
      wr(DOR_OFS_POP, 8'h00);
      chk(cm_bandgap_sel_o, 0);
      wr(DOR_OFS_SWITCH, 8'h00);
      wr(DOR_OFS_LVOL, 8'h00);
      wr(DOR_OFS_RVOL, 8'h8c);
      for (int k = 0; k < 4; k++) begin
         s = {2'b00, 20'($urandom), 2'b00};
         send(s, s);
         chk(left_sample_o, s);
         chk(right_sample_o, 0);
      end
      wr(DOR_OFS_RVOL, 8'h0c);
      s = {2'b00, 20'($urandom), 2'b00};
      send(s, -s);
      chk(right_sample_o, -(s >>> 1));
      wr(DOR_OFS_LVOL, 8'h80);
      wr(DOR_OFS_RVOL, 8'h00);
      s = {2'b00, 20'($urandom), 2'b00};
      send(s, s);
      chk(left_sample_o, 0);
      chk(right_sample_o, s);
      // 100 us delay, 1 ms ramp step
      // legal delay code, reserved zero
      wr(DOR_OFS_POP, 8'h24);
      @(negedge core_clk_i);
      drv_power_req_i = 1'b1;
      t0 = cycles;
      while (!drv_on_o && cycles - t0 < 1000) @(negedge core_clk_i);
      chk((cycles - t0) >= 100 * CPT - 2 * CPT && (cycles - t0) <= 100 * CPT + 2 * CPT, 1);
      n = 0;
      last = cycles;
      gap = 0;
      while (drv_ramp_done_o !== 1'b1 && cycles - t0 < 10000) begin
         @(negedge core_clk_i);
         if (drv_ramp_step_o === 1'b1) begin
            n++;
            gap = cycles - last;
            last = cycles;
         end
      end
      chk(n, 2);
      chk(gap >= 1000 * CPT - 2 * CPT && gap <= 1000 * CPT + 2 * CPT, 1);
      drv_power_req_i = 1'b0;
      repeat (2) @(negedge core_clk_i);
      chk({drv_on_o, drv_ramp_done_o}, 2'b00);
      // zero delay, zero step time
      wr(DOR_OFS_POP, 8'h00);
      @(negedge core_clk_i);
      drv_power_req_i = 1'b1;
      t0 = cycles;
      @(negedge core_clk_i);
      chk(drv_on_o, 0);
      @(negedge core_clk_i);
      chk(drv_on_o, 1);
      n = 0;
      while (drv_ramp_done_o !== 1'b1 && cycles - t0 < 20) begin
         @(negedge core_clk_i);
         if (drv_ramp_step_o === 1'b1) n++;
      end
      chk(n, 2);
      drv_power_req_i = 1'b0;
      stop_test();
   end
endmodule
